// ===== hw/tdb_edge_if.sv
`timescale 1ns/10ps
// synchronised pin levels and test clock edge strobes
interface tdb_edge_if;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;
  modport src (output tck_rise, output tck_fall, output tms, output tdi);
  modport dst (input tck_rise, input tck_fall, input tms, input tdi);
endinterface : tdb_edge_if

// ===== hw/tdb_pin_sync.sv
`timescale 1ns/10ps
module tdb_pin_sync
  import tdb_pkg::*;
(
  // clock and reset
  input  wire logic clock,
  input  wire logic rst,
  // raw pins
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  // synchronised view
  tdb_edge_if.src   edge_out
);
  logic [TDB_SYNC_STAGES-1:0] sync_tck;
  logic [TDB_SYNC_STAGES-1:0] sync_tms;
  logic [TDB_SYNC_STAGES-1:0] sync_tdi;
  logic                       tck_last;
  logic [TDB_SYNC_STAGES-1:0] next_sync_tck;
  logic [TDB_SYNC_STAGES-1:0] next_sync_tms;
  logic [TDB_SYNC_STAGES-1:0] next_sync_tdi;
  logic                       next_tck_last;

  // two flops per pin; only the second stage and tck_last feed any logic
  always_comb begin
    next_sync_tck = {sync_tck[0], tck};
    next_sync_tms = {sync_tms[0], tms};
    next_sync_tdi = {sync_tdi[0], tdi};
    next_tck_last = sync_tck[1];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sync_tck <= '0;
      sync_tms <= '0;
      sync_tdi <= '0;
      tck_last <= TDB_RESET_BIT;
    end else begin
      sync_tck <= next_sync_tck;
      sync_tms <= next_sync_tms;
      sync_tdi <= next_sync_tdi;
      tck_last <= next_tck_last;
    end
  end

  // edge strobes: one clock wide, taken from the synchronised level
  assign edge_out.tck_rise = sync_tck[1] & ~tck_last;
  assign edge_out.tck_fall = ~sync_tck[1] & tck_last;
  assign edge_out.tms      = sync_tms[1];
  assign edge_out.tdi      = sync_tdi[1];
endmodule : tdb_pin_sync

// ===== hw/tdb_pkg.sv
// Operation
// - With bypass selected, a zero is loaded into the bypass stage on the rising test clock edge leaving capture-data.
// - On the falling test clock edge after entering shift-data, the serial output leaves high impedance and is driven.
// - The controller sets serial input with the falling edge; one bit is shifted in on each rising edge in shift-data, including the exit edge.
// - On the falling edge while in exit1-data, the serial output returns to high impedance.
// - On the falling edge in update-data, the shifted value is moved into the selected register's output stage.
// - From update-data the controller can walk through select-data and select-instruction scan to reset, where test operation ends.
// - Serial input and mode select are sampled on rising edges, the serial output changes only on falling edges, and the state advances on each rising edge.
package tdb_pkg;

  // port controller states, standard sixteen-state walk
  typedef enum logic [3:0] {
    tdb_reset, tdb_idle, tdb_sel_dr, tdb_cap_dr, tdb_shift_dr, tdb_exit1_dr,
    tdb_pause_dr, tdb_exit2_dr, tdb_upd_dr, tdb_sel_ir, tdb_cap_ir,
    tdb_shift_ir, tdb_exit1_ir, tdb_pause_ir, tdb_exit2_ir, tdb_upd_ir
  } tdb_state_type;

  localparam logic TDB_BYPASS_CAPTURE = 1'h0;  // value captured into bypass
  localparam logic TDB_RESET_BIT      = 1'h0;  // reset value of one-bit stages
  localparam logic TDB_OE_IDLE        = 1'h1;  // output enable at rest: pin floats
  localparam logic TDB_DONE_RESET     = 1'h1;  // done flag out of reset: port sits in reset
  localparam int   TDB_SYNC_STAGES    = 2;     // pin synchroniser depth

endpackage : tdb_pkg

// ===== hw/tdb_scan_port.sv
`timescale 1ns/10ps
module tdb_scan_port
  import tdb_pkg::*;
(
  // clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // test access pins
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tdi,
  output logic                    tdo_out,
  output logic                    tdo_oe_n,
  // status
  output tdb_pkg::tdb_state_type  tap_state,
  output logic                    bypass_update,
  output logic                    test_done
);
  import tdb_pkg::*;

  tdb_edge_if edges ();

  tdb_pin_sync u_sync (
    .clock    (clock),
    .rst      (rst),
    .tck      (tck),
    .tms      (tms),
    .tdi      (tdi),
    .edge_out (edges)
  );

  tdb_state_type state;
  tdb_state_type next_state;
  logic          bypass_bit;
  logic          next_bypass_bit;
  logic          next_tdo_out;
  logic          next_tdo_oe_n;
  logic          next_bypass_update;
  logic          next_test_done;

  // state walk on each rising test clock edge, steered by mode select
  always_comb begin
    next_state = state;
    if (edges.tck_rise) begin
      case (state)
        tdb_reset:    next_state = edges.tms ? tdb_reset    : tdb_idle;
        tdb_idle:     next_state = edges.tms ? tdb_sel_dr   : tdb_idle;
        tdb_sel_dr:   next_state = edges.tms ? tdb_sel_ir   : tdb_cap_dr;
        tdb_cap_dr:   next_state = edges.tms ? tdb_exit1_dr : tdb_shift_dr;
        tdb_shift_dr: next_state = edges.tms ? tdb_exit1_dr : tdb_shift_dr;
        tdb_exit1_dr: next_state = edges.tms ? tdb_upd_dr   : tdb_pause_dr;
        tdb_pause_dr: next_state = edges.tms ? tdb_exit2_dr : tdb_pause_dr;
        tdb_exit2_dr: next_state = edges.tms ? tdb_upd_dr   : tdb_shift_dr;
        tdb_upd_dr:   next_state = edges.tms ? tdb_sel_dr   : tdb_idle;
        tdb_sel_ir:   next_state = edges.tms ? tdb_reset    : tdb_cap_ir;
        tdb_cap_ir:   next_state = edges.tms ? tdb_exit1_ir : tdb_shift_ir;
        tdb_shift_ir: next_state = edges.tms ? tdb_exit1_ir : tdb_shift_ir;
        tdb_exit1_ir: next_state = edges.tms ? tdb_upd_ir   : tdb_pause_ir;
        tdb_pause_ir: next_state = edges.tms ? tdb_exit2_ir : tdb_pause_ir;
        tdb_exit2_ir: next_state = edges.tms ? tdb_upd_ir   : tdb_shift_ir;
        tdb_upd_ir:   next_state = edges.tms ? tdb_sel_dr   : tdb_idle;
        default:      next_state = tdb_reset;
      endcase
    end
  end

  // bypass stage: capture zero, then one bit per rising edge while shifting
  always_comb begin
    next_bypass_bit = bypass_bit;
    if (edges.tck_rise) begin
      if (state == tdb_cap_dr)
        next_bypass_bit = TDB_BYPASS_CAPTURE;
      else if (state == tdb_shift_dr)
        next_bypass_bit = edges.tdi;
    end
  end

  // serial output changes only on falling edges; the data lags one half
  // cycle behind the stage so the controller samples a settled value
  always_comb begin
    next_tdo_out       = tdo_out;
    next_tdo_oe_n      = tdo_oe_n;
    next_bypass_update = bypass_update;
    if (edges.tck_fall) begin
      if (state == tdb_shift_dr || state == tdb_shift_ir) begin
        next_tdo_oe_n = 1'h0;
        next_tdo_out  = bypass_bit;
      end else begin
        next_tdo_oe_n = 1'h1;
      end
      if (state == tdb_upd_dr)
        next_bypass_update = bypass_bit;
    end
  end

  // test operation over once the walk lands back in reset
  always_comb begin
    next_test_done = (next_state == tdb_reset);
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state         <= tdb_reset;
      bypass_bit    <= TDB_RESET_BIT;
      tdo_out       <= TDB_RESET_BIT;
      tdo_oe_n      <= TDB_OE_IDLE;
      bypass_update <= TDB_RESET_BIT;
      test_done     <= TDB_DONE_RESET;
      tap_state     <= tdb_reset;
    end else begin
      state         <= next_state;
      bypass_bit    <= next_bypass_bit;
      tdo_out       <= next_tdo_out;
      tdo_oe_n      <= next_tdo_oe_n;
      bypass_update <= next_bypass_update;
      test_done     <= next_test_done;
      tap_state     <= next_state;
    end
  end
endmodule : tdb_scan_port

// ===== sim/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import tdb_pkg::*;
  logic          clock = 1'h0;
  logic          rst   = 1'h1;
  wire logic     tck, tms, tdi;
  logic          tdo_out, tdo_oe_n, bypass_update, test_done;
  tdb_state_type tap_state;
  int            n_mismatch = 0, n_tests = 0, n_cyc = 0;
  // low enable drives the pin, otherwise it floats
  wire logic     tdo_pin = tdo_oe_n ? 1'bz : tdo_out;
  initial begin
    forever #4 clock = ~clock;
  end
  tdb_ctl_model tdb_ctl_model_inst (.clock(clock), .tck(tck), .tms(tms), .tdi(tdi));
  tdb_scan_port tdb_scan_port_inst (.clock(clock), .rst(rst), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .tap_state(tap_state),
    .bypass_update(bypass_update), .test_done(test_done));
  task automatic conclude();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk
  // state is that after this rise; pin shows the fall before it (x skips)
  task automatic step(input logic t, d, input tdb_state_type s, input logic o);
    tdb_ctl_model_inst.cyc(t, d);
    chk("state", s, tap_state);
    if (o !== 1'bx) chk("tdo", o, tdo_pin);
  endtask : step
  task automatic scan_walk();
    step(1'h0, 1'h0, tdb_idle, 1'bz);
    step(1'h1, 1'h0, tdb_sel_dr, 1'bz);
    step(1'h0, 1'h0, tdb_cap_dr, 1'bz);
    step(1'h0, 1'h0, tdb_shift_dr, 1'bz);
    step(1'h0, 1'h1, tdb_shift_dr, 1'h0);
    step(1'h0, 1'h0, tdb_shift_dr, 1'h1);
    step(1'h1, 1'h1, tdb_exit1_dr, 1'h0);
    step(1'h1, 1'h0, tdb_upd_dr, 1'bz);
    step(1'h1, 1'h0, tdb_sel_dr, 1'bx);
    chk("update", 1'h1, bypass_update);
    step(1'h1, 1'h0, tdb_sel_ir, 1'bz);
    step(1'h1, 1'h0, tdb_reset, 1'bz);
    chk("done", 1'h1, test_done);
    $display("scan_walk done");
  endtask : scan_walk
  // capture then update with no shift: the update stage must take the zero
  task automatic no_shift();
    step(1'h0, 1'h1, tdb_idle, 1'bz);
    step(1'h1, 1'h1, tdb_sel_dr, 1'bz);
    step(1'h0, 1'h1, tdb_cap_dr, 1'bz);
    step(1'h1, 1'h1, tdb_exit1_dr, 1'bz);
    step(1'h1, 1'h1, tdb_upd_dr, 1'bz);
    step(1'h0, 1'h1, tdb_idle, 1'bz);
    chk("update", 1'h0, bypass_update);
    chk("done", 1'h0, test_done);
    $display("no_shift done");
  endtask : no_shift
  initial begin
    repeat (10) @(posedge clock);
    rst <= 1'h0;
    @(posedge clock);
    chk("done", 1'h1, test_done);
    scan_walk();
    no_shift();
    tdb_ctl_model_inst.park();
    conclude();
  end
  // a hang is cut short well past the expected run of about 180 cycles
  always @(posedge clock) begin
    n_cyc++;
    if (n_cyc == 2000) begin
      n_mismatch++;
      conclude();
    end
  end
endmodule : tb_top
bind tdb_scan_port tdb_chk tdb_chk_inst (.clock(clock), .rst(rst), .tck(tck), .tms(tms),
  .tdi(tdi), .tdo_out(tdo_out), .tdo_oe_n(tdo_oe_n), .tap_state(tap_state),
  .bypass_update(bypass_update), .test_done(test_done));

// ===== sim/tdb_chk.sv
`timescale 1ns/10ps
module tdb_chk
  import tdb_pkg::*;
(
  // clock and reset
  input wire logic          clock, rst,
  // pins and status
  input wire logic          tck, tms, tdi, tdo_out, tdo_oe_n, bypass_update, test_done,
  input wire tdb_state_type tap_state
);
  // one domain, so clock and reset are given once for every property
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  done_tracks_reset_a: assert property (test_done == (tap_state == tdb_reset))
    else $error("done flag differs from reset state");
  oe_on_fall_a: assert property ($changed(tdo_oe_n) |-> !tck)
    else $error("output enable moved while test clock high");
  tdo_on_fall_a: assert property ($changed(tdo_out) |-> !tck)
    else $error("serial output moved while test clock high");
  state_on_rise_a: assert property ($changed(tap_state) |-> tck)
    else $error("state moved while test clock low");
  drive_in_shift_a: assert property ($fell(tdo_oe_n) |-> tap_state inside {tdb_shift_dr, tdb_shift_ir})
    else $error("output driven outside shift");
  float_in_exit_a: assert property ($rose(tdo_oe_n) |-> tap_state inside {tdb_exit1_dr, tdb_exit1_ir})
    else $error("output released outside exit1");
  update_only_a: assert property ($changed(bypass_update) |-> tap_state == tdb_upd_dr)
    else $error("update stage moved outside update state");
  // the first driven bit must be the captured zero, within one test clock period
  capture_zero_a: assert property ($past(tap_state) == tdb_cap_dr && tap_state == tdb_shift_dr
    |-> ##[1:10] (!tdo_oe_n && !tdo_out))
    else $error("captured zero not shown");
  cover property (tap_state == tdb_shift_dr && !tdo_oe_n);
  cover property ($rose(bypass_update));
  cover property ($rose(test_done));
endmodule : tdb_chk

// ===== sim/tdb_ctl_model.sv
`timescale 1ns/10ps
module tdb_ctl_model (
  // system clock paces the test clock
  input wire logic clock,
  // test access pins
  output logic     tck,
  output logic     tms,
  output logic     tdi
);
  initial begin
    tck = 1'h0;
    tms = 1'h1;
    tdi = 1'h0;
  end
  // one 80 ns test clock period; mode and data move with the falling edge
  task automatic cyc(input logic t, input logic d);
    tck <= 1'h0;
    tms <= t;
    tdi <= d;
    repeat (5) @(posedge clock);
    tck <= 1'h1;
    repeat (5) @(posedge clock);
  endtask : cyc
  // the test clock stands low between frames
  task automatic park();
    tck <= 1'h0;
  endtask : park
endmodule : tdb_ctl_model
